// >>> synth_cfg_pkg.sv
// synth_cfg_pkg: constants for the synthesizer serial configuration bank
// assumes: shared by the bank and its capture helper
package synth_cfg_pkg;
    localparam int WORD_W        = 32;
    localparam int SEL_W         = 3;
    localparam int INT_W         = 12;
    localparam int FRAC_W        = 25;
    localparam int FRAC_HI_W     = 12;
    localparam int FRAC_LO_W     = 13;
    localparam int RDIV_W        = 5;
    localparam int MON_W         = 4;
    localparam int CPI_W         = 4;
    localparam int CLKDIV_W      = 12;
    // latch select codes
    localparam logic [2:0] SEL_W0 = 3'h0;
    localparam logic [2:0] SEL_W1 = 3'h1;
    localparam logic [2:0] SEL_W2 = 3'h2;
    localparam logic [2:0] SEL_W3 = 3'h3;
    localparam logic [2:0] SEL_W4 = 3'h4;
    // word 0 fields
    localparam int W0_MON_LSB    = 27;
    localparam int W0_INT_LSB    = 15;
    localparam int W0_FHI_LSB    = 3;
    // word 1 fields
    localparam int W1_FLO_LSB    = 15;
    // word 2 fields
    localparam int W2_CSR_BIT    = 28;
    localparam int W2_CPI_LSB    = 24;
    localparam int W2_PRE_BIT    = 22;
    localparam int W2_HALF_BIT   = 21;
    localparam int W2_DBL_BIT    = 20;
    localparam int W2_RDIV_LSB   = 15;
    // word 3 fields
    localparam int W3_SDRST_BIT  = 14;
    localparam int W3_LDP_BIT    = 7;
    localparam int W3_POL_BIT    = 6;
    localparam int W3_PD_BIT     = 5;
    localparam int W3_TRI_BIT    = 4;
    localparam int W3_CRST_BIT   = 3;
    // word 4 fields
    localparam int W4_NB_LSB     = 23;
    localparam int W4_CKM_LSB    = 19;
    localparam int W4_CKD_LSB    = 7;
    // divider limits
    localparam logic [11:0] INT_MIN = 12'h017;
    localparam logic [11:0] INT_MAX = 12'hfff;
    // monitor select codes
    localparam logic [3:0] MON_TRI    = 4'h0;
    localparam logic [3:0] MON_HIGH   = 4'h1;
    localparam logic [3:0] MON_LOW    = 4'h2;
    localparam logic [3:0] MON_RDIV   = 4'h3;
    localparam logic [3:0] MON_NDIV   = 4'h4;
    localparam logic [3:0] MON_LOCK   = 4'h6;
    localparam logic [3:0] MON_SERIAL = 4'hf;
endpackage : synth_cfg_pkg

// >>> serial_bus_if.sv
// serial_bus_if: synchronised link strobes from capture to the bank
// assumes: single clock domain
`timescale 1ns/1ps
`default_nettype none
interface serial_bus_if;
    import synth_cfg_pkg::*;
    logic              load_pulse;
    logic [WORD_W-1:0] word;
    modport capture (output load_pulse, output word);
    modport bank    (input load_pulse, input word);
endinterface : serial_bus_if
`default_nettype wire

// >>> serial_capture.sv
// serial_capture: synchronises the three-wire link and shifts in words
// assumes: serial clock well below half the system clock
`timescale 1ns/1ps
`default_nettype none
module serial_capture (
    input  wire logic   clock,
    input  wire logic   resetn,
    input  wire logic   clock_en,
    input  wire logic   serial_clock,
    input  wire logic   serial_data,
    input  wire logic   load_strobe,
    serial_bus_if.capture bus
);
    import synth_cfg_pkg::*;

    logic [2:0]        s1_q, s2_q, s2_d, s1_d, prev_q, prev_d;
    logic [WORD_W-1:0] shift_q, shift_d;
    logic              pulse_q, pulse_d;

    always_comb begin
        s1_d    = {serial_clock, serial_data, load_strobe};
        s2_d    = s1_q;
        prev_d  = s2_q;
        shift_d = shift_q;
        pulse_d = 1'b0;
        // msb first, shift on rising serial clock
        if (s2_q[2] && !prev_q[2]) begin
            shift_d = {shift_q[WORD_W-2:0], s2_q[1]};
        end
        if (s2_q[0] && !prev_q[0]) begin
            pulse_d = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            s1_q    <= '0;
            s2_q    <= '0;
            prev_q  <= '0;
            shift_q <= '0;
            pulse_q <= 1'b0;
        end else if (clock_en) begin
            s1_q    <= s1_d;
            s2_q    <= s2_d;
            prev_q  <= prev_d;
            shift_q <= shift_d;
            pulse_q <= pulse_d;
        end
    end

    assign bus.load_pulse = pulse_q;
    assign bus.word       = shift_q;

    property p_shift_msb_first;
        @(posedge clock) disable iff (!resetn)
        (clock_en && s2_q[2] && !prev_q[2]) |=> shift_q[0] == $past(s2_q[1]);
    endproperty
    a_shift_msb_first: assert property (p_shift_msb_first) else $error("shift bit lost");
endmodule : serial_capture
`default_nettype wire

// >>> synth_serial_config_bank.sv
// synth_serial_config_bank: write-only configuration latches of the synthesizer
// assumes: serial pins asynchronous to clock; host keeps the strobe low while shifting
//
// What this block does
// - serial data shifts into a 32-bit register, msb first, on rising serial clock
// - rising load strobe copies the shift register into one of five latches
// - low three bits 000..100 select words 0..4; host places the code
// - integer divider is 12 bits; only 23 to 4095 valid
// - fractional numerator is 25 bits against modulus two to the 25th
// - reference divider is 5 bits, ratios 1 through 32
// - phase detector rate is ref times (1+doubler) over R times (1+halving)
// - low fraction, R, doubler, pump current apply only on a later word 0 write
// - host writes low fraction before word 0; change starts at word 0 write
// - word 0 bits 30:27 monitor select, bits 26:15 integer value
// - word 0 bits 14:3 upper fraction bits, bit 31 reserved zero
// - word 1 bits 27:15 lower thirteen fraction bits, rest reserved
// - word 4 holds bleed control, clock divider mode and 12-bit divider value
// - monitor output routes the point chosen by the word 0 select bits
// - modulator resets on every word 0 write unless its control bit is one
// - power-down holds counters in load state and resets lock detect
`timescale 1ns/1ps
`default_nettype none
module synth_serial_config_bank (
    input  wire logic                          clock,
    input  wire logic                          resetn,
    input  wire logic                          clock_en,
    input  wire logic                          serial_clock,
    input  wire logic                          serial_data,
    input  wire logic                          load_strobe,
    input  wire logic                          ref_div_point,
    input  wire logic                          n_div_point,
    input  wire logic                          lock_point,
    output logic                               monitor_output,
    output logic                               monitor_output_en,
    output logic [synth_cfg_pkg::INT_W-1:0]    int_value,
    output logic                               int_valid,
    output logic [synth_cfg_pkg::FRAC_W-1:0]   frac_value,
    output logic [synth_cfg_pkg::RDIV_W-1:0]   ref_div_code,
    output logic [synth_cfg_pkg::RDIV_W:0]     ref_div_ratio,
    output logic                               ref_doubler,
    output logic                               ref_halving_flag,
    output logic [synth_cfg_pkg::CPI_W-1:0]    pump_current_code,
    output logic                               cycle_slip_reduction,
    output logic                               prescaler_select,
    output logic                               modulator_reset,
    output logic                               freq_update,
    output logic                               lock_detect_precision,
    output logic                               pd_polarity,
    output logic                               power_down,
    output logic                               pump_tristate,
    output logic                               counter_reset,
    output logic                               counters_hold,
    output logic                               lock_detect_clear,
    output logic [1:0]                         negative_bleed_control,
    output logic [1:0]                         clock_divider_mode,
    output logic [synth_cfg_pkg::CLKDIV_W-1:0] clock_divider_value
);
    import synth_cfg_pkg::*;

    // ----------------------------------------
    // link capture
    // ----------------------------------------
    serial_bus_if bus ();

    serial_capture u_capture (
        .clock        (clock),
        .resetn       (resetn),
        .clock_en     (clock_en),
        .serial_clock (serial_clock),
        .serial_data  (serial_data),
        .load_strobe  (load_strobe),
        .bus          (bus)
    );

    // ----------------------------------------
    // latches and double buffers
    // ----------------------------------------
    logic [WORD_W-1:0] w0_q, w1_q, w2_q, w3_q, w4_q;
    logic [WORD_W-1:0] w0_d, w1_d, w2_d, w3_d, w4_d;
    logic [FRAC_LO_W-1:0] flo_act_q, flo_act_d;
    logic [RDIV_W-1:0]    rdiv_act_q, rdiv_act_d;
    logic                 dbl_act_q, dbl_act_d;
    logic [CPI_W-1:0]     cpi_act_q, cpi_act_d;
    logic                 upd_q, upd_d, sdr_q, sdr_d;
    logic                 mon_q, mon_d, mon_en_q, mon_en_d;
    logic [SEL_W-1:0]     sel;
    logic                 wr0;

    assign sel = bus.word[SEL_W-1:0];
    assign wr0 = bus.load_pulse && (sel == SEL_W0);

    always_comb begin
        w0_d       = w0_q;
        w1_d       = w1_q;
        w2_d       = w2_q;
        w3_d       = w3_q;
        w4_d       = w4_q;
        flo_act_d  = flo_act_q;
        rdiv_act_d = rdiv_act_q;
        dbl_act_d  = dbl_act_q;
        cpi_act_d  = cpi_act_q;
        upd_d      = 1'b0;
        sdr_d      = 1'b0;
        if (bus.load_pulse) begin
            unique case (sel)
                SEL_W0:  w0_d = bus.word;
                SEL_W1:  w1_d = bus.word;
                SEL_W2:  w2_d = bus.word;
                SEL_W3:  w3_d = bus.word;
                SEL_W4:  w4_d = bus.word;
                default: ;
            endcase
        end
        // buffered fields move on word 0 write only
        if (wr0) begin
            flo_act_d  = w1_q[W1_FLO_LSB +: FRAC_LO_W];
            rdiv_act_d = w2_q[W2_RDIV_LSB +: RDIV_W];
            dbl_act_d  = w2_q[W2_DBL_BIT];
            cpi_act_d  = w2_q[W2_CPI_LSB +: CPI_W];
            upd_d      = 1'b1;
            sdr_d      = !w3_q[W3_SDRST_BIT];
        end
    end

    // ----------------------------------------
    // monitor multiplexer
    // ----------------------------------------
    always_comb begin
        mon_d    = 1'b0;
        mon_en_d = 1'b1;
        unique case (w0_q[W0_MON_LSB +: MON_W])
            MON_TRI:    mon_en_d = 1'b0;
            MON_HIGH:   mon_d = 1'b1;
            MON_LOW:    mon_d = 1'b0;
            MON_RDIV:   mon_d = ref_div_point;
            MON_NDIV:   mon_d = n_div_point;
            MON_LOCK:   mon_d = lock_point && !w3_q[W3_PD_BIT];
            MON_SERIAL: mon_d = bus.word[WORD_W-1];
            default:    mon_d = 1'b0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            w0_q       <= '0;
            w1_q       <= '0;
            w2_q       <= '0;
            w3_q       <= '0;
            w4_q       <= '0;
            flo_act_q  <= '0;
            rdiv_act_q <= '0;
            dbl_act_q  <= 1'b0;
            cpi_act_q  <= '0;
            upd_q      <= 1'b0;
            sdr_q      <= 1'b0;
            mon_q      <= 1'b0;
            mon_en_q   <= 1'b0;
        end else if (clock_en) begin
            w0_q       <= w0_d;
            w1_q       <= w1_d;
            w2_q       <= w2_d;
            w3_q       <= w3_d;
            w4_q       <= w4_d;
            flo_act_q  <= flo_act_d;
            rdiv_act_q <= rdiv_act_d;
            dbl_act_q  <= dbl_act_d;
            cpi_act_q  <= cpi_act_d;
            upd_q      <= upd_d;
            sdr_q      <= sdr_d;
            mon_q      <= mon_d;
            mon_en_q   <= mon_en_d;
        end
    end

    // ----------------------------------------
    // registered derived outputs
    // ----------------------------------------
    logic [INT_W-1:0]  int_next;
    logic [RDIV_W:0]   ratio_q, ratio_d;
    logic              valid_q, valid_d;
    logic              tri_q, tri_d;
    logic              hold_q, hold_d;

    // built from next latch values so they move with the fields
    always_comb begin
        int_next = w0_d[W0_INT_LSB +: INT_W];
        valid_d  = (int_next >= INT_MIN) && (int_next <= INT_MAX);
        ratio_d  = (rdiv_act_d == '0) ? {1'b1, {RDIV_W{1'b0}}} : {1'b0, rdiv_act_d};
        tri_d    = w3_d[W3_TRI_BIT] || w3_d[W3_PD_BIT];
        hold_d   = w3_d[W3_PD_BIT] || w3_d[W3_CRST_BIT];
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            valid_q <= 1'b0;
            ratio_q <= {1'b1, {RDIV_W{1'b0}}};
            tri_q   <= 1'b0;
            hold_q  <= 1'b0;
        end else if (clock_en) begin
            valid_q <= valid_d;
            ratio_q <= ratio_d;
            tri_q   <= tri_d;
            hold_q  <= hold_d;
        end
    end

    // ----------------------------------------
    // field outputs
    // ----------------------------------------
    logic [INT_W-1:0] int_field;
    assign int_field = w0_q[W0_INT_LSB +: INT_W];

    assign monitor_output         = mon_q;
    assign monitor_output_en      = mon_en_q;
    assign int_value              = int_field;
    assign int_valid              = valid_q;
    assign frac_value             = {w0_q[W0_FHI_LSB +: FRAC_HI_W], flo_act_q};
    assign ref_div_code           = rdiv_act_q;
    assign ref_div_ratio          = ratio_q;
    assign ref_doubler            = dbl_act_q;
    assign ref_halving_flag       = w2_q[W2_HALF_BIT];
    assign pump_current_code      = cpi_act_q;
    assign cycle_slip_reduction   = w2_q[W2_CSR_BIT];
    assign prescaler_select       = w2_q[W2_PRE_BIT];
    assign modulator_reset        = sdr_q;
    assign freq_update            = upd_q;
    assign lock_detect_precision  = w3_q[W3_LDP_BIT];
    assign pd_polarity            = w3_q[W3_POL_BIT];
    assign power_down             = w3_q[W3_PD_BIT];
    assign pump_tristate          = tri_q;
    assign counter_reset          = w3_q[W3_CRST_BIT];
    assign counters_hold          = hold_q;
    assign lock_detect_clear      = w3_q[W3_PD_BIT];
    assign negative_bleed_control = w4_q[W4_NB_LSB +: 2];
    assign clock_divider_mode     = w4_q[W4_CKM_LSB +: 2];
    assign clock_divider_value    = w4_q[W4_CKD_LSB +: CLKDIV_W];

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_latch_w0;
        @(posedge clock) disable iff (!resetn)
        (clock_en && wr0) |=> w0_q == $past(bus.word);
    endproperty
    a_latch_w0: assert property (p_latch_w0) else $error("word 0 not latched");

    property p_sel_w4;
        @(posedge clock) disable iff (!resetn)
        (clock_en && bus.load_pulse && sel == SEL_W4) |=> clock_divider_value == $past(bus.word[W4_CKD_LSB +: CLKDIV_W]);
    endproperty
    a_sel_w4: assert property (p_sel_w4) else $error("word 4 decode wrong");

    property p_int_range;
        @(posedge clock) disable iff (!resetn)
        int_valid == (int_value >= INT_MIN);
    endproperty
    a_int_range: assert property (p_int_range) else $error("integer range flag wrong");

    property p_flo_hold;
        @(posedge clock) disable iff (!resetn)
        (clock_en && !wr0) |=> $stable(frac_value[FRAC_LO_W-1:0]);
    endproperty
    a_flo_hold: assert property (p_flo_hold) else $error("low fraction moved early");

    property p_flo_apply;
        @(posedge clock) disable iff (!resetn)
        (clock_en && wr0) |=> frac_value[FRAC_LO_W-1:0] == $past(w1_q[W1_FLO_LSB +: FRAC_LO_W]) && freq_update;
    endproperty
    a_flo_apply: assert property (p_flo_apply) else $error("low fraction not applied");

    property p_sdreset;
        @(posedge clock) disable iff (!resetn)
        (clock_en && wr0) |=> modulator_reset == !$past(w3_q[W3_SDRST_BIT]);
    endproperty
    a_sdreset: assert property (p_sdreset) else $error("modulator reset wrong");

    property p_pd;
        @(posedge clock) disable iff (!resetn)
        power_down |-> counters_hold && lock_detect_clear;
    endproperty
    a_pd: assert property (p_pd) else $error("power-down not holding");

    property p_w2_keep;
        @(posedge clock) disable iff (!resetn)
        !(bus.load_pulse && sel == SEL_W2) |=> $stable(w2_q);
    endproperty
    a_w2_keep: assert property (p_w2_keep) else $error("word 2 changed unaddressed");

    property p_rdiv_ratio;
        @(posedge clock) disable iff (!resetn)
        ref_div_ratio >= 6'h01 && ref_div_ratio <= 6'h20;
    endproperty
    a_rdiv_ratio: assert property (p_rdiv_ratio) else $error("R ratio out of range");

    property p_mon_tri;
        @(posedge clock) disable iff (!resetn)
        (clock_en && w0_q[W0_MON_LSB +: MON_W] == MON_TRI) |=> !monitor_output_en;
    endproperty
    a_mon_tri: assert property (p_mon_tri) else $error("monitor driven while off");

    property p_upd_pulse;
        @(posedge clock) disable iff (!resetn)
        (clock_en && freq_update) |=> !freq_update;
    endproperty
    a_upd_pulse: assert property (p_upd_pulse) else $error("update pulse too long");
endmodule : synth_serial_config_bank
`default_nettype wire

// >>> serial_host_model.sv
// serial_host_model: host controller on the three-wire configuration link
// assumes: stepped by the bench clock; serial clock stands low between frames
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
    input  wire logic clock,
    output logic      serial_clock,
    output logic      serial_data,
    output logic      load_strobe
);
    initial begin
        serial_clock = 1'b0;
        serial_data  = 1'b0;
        load_strobe  = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clock);
    endtask : hold

    // ----------------------------------------
    // one word, msb first; half sets the pace
    // ----------------------------------------
    task automatic write_word(input logic [31:0] w, input int half, input bit commit);
        for (int i = 31; i >= 0; i--) begin
            serial_data <= w[i];
            hold(half);
            serial_clock <= 1'b1;
            hold(half);
            serial_clock <= 1'b0;
        end
        hold(half);
        if (commit) begin
            // data line no longer meaningful once all bits are in
            serial_data <= ~w[0];
            load_strobe <= 1'b1;
            hold(4);
            load_strobe <= 1'b0;
        end
    endtask : write_word
endmodule : serial_host_model
`default_nettype wire

// >>> synth_serial_config_bank_tb_top.sv
// synth_serial_config_bank_tb_top: self-checking bench for the configuration bank
// assumes: host model drives the link; the bench keeps a shadow of every latch
`timescale 1ns/1ps
`default_nettype none
module synth_serial_config_bank_tb_top;
    import synth_cfg_pkg::*;
    logic clock, resetn, clock_en, ref_div_point, n_div_point, lock_point;
    logic serial_clock, serial_data, load_strobe;
    logic monitor_output, monitor_output_en, int_valid, ref_doubler, ref_halving_flag, cycle_slip_reduction;
    logic prescaler_select, modulator_reset, freq_update, lock_detect_precision, pd_polarity, power_down;
    logic pump_tristate, counter_reset, counters_hold, lock_detect_clear;
    logic [INT_W-1:0]    int_value;
    logic [FRAC_W-1:0]   frac_value;
    logic [RDIV_W-1:0]   ref_div_code;
    logic [5:0]          ref_div_ratio;
    logic [CPI_W-1:0]    pump_current_code;
    logic [1:0]          negative_bleed_control, clock_divider_mode;
    logic [CLKDIV_W-1:0] clock_divider_value;
    logic [31:0]         w0, w1, w2, w3, w4;
    logic [12:0]         a_flo;
    logic [4:0]          a_rdiv;
    logic [3:0]          a_cpi;
    logic                a_dbl;
    logic [31:0]         last_w;
    int                  miscompares, n_checks, n_upd, n_mrst, upd0;
    logic [31:0]         mask [5] = '{32'h7fff_fff8, 32'h0fff_8000, 32'h1f7f_8000, 32'h0000_40f8, 32'h019f_ff80};
    int                  ints [4] = '{22, 23, 4095, 1000};
    int                  mons [8] = '{0, 1, 2, 3, 4, 6, 5, 15};

    serial_host_model host (.clock, .serial_clock, .serial_data, .load_strobe);
    synth_serial_config_bank dut (
        .clock, .resetn, .clock_en, .serial_clock, .serial_data, .load_strobe, .ref_div_point,
        .n_div_point, .lock_point, .monitor_output, .monitor_output_en, .int_value, .int_valid,
        .frac_value, .ref_div_code, .ref_div_ratio, .ref_doubler, .ref_halving_flag,
        .pump_current_code, .cycle_slip_reduction, .prescaler_select, .modulator_reset,
        .freq_update, .lock_detect_precision, .pd_polarity, .power_down, .pump_tristate,
        .counter_reset, .counters_hold, .lock_detect_clear, .negative_bleed_control,
        .clock_divider_mode, .clock_divider_value);

    always #12.5 clock = ~clock;

    always @(posedge clock) begin
        if (freq_update === 1'b1) n_upd++;
        if (modulator_reset === 1'b1) n_mrst++;
    end

    // ----------------------------------------
    // expectations and comparison
    // ----------------------------------------
    function automatic logic [5:0] ratio(input logic [4:0] c);
        return (c == 5'h00) ? 6'h20 : {1'b0, c};
    endfunction : ratio

    function automatic logic [31:0] mk(input logic [2:0] sel);
        return ($urandom() & mask[sel]) | {29'h0, sel};
    endfunction : mk

    function automatic logic mon_exp(input logic [3:0] s);
        case (s)
            4'h1: return 1'b1;
            4'h3: return ref_div_point;
            4'h4: return n_div_point;
            4'h6: return lock_point & ~w3[5];
            4'hf: return last_w[31];
            default: return 1'b0;
        endcase
    endfunction : mon_exp

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic check_all();
        chk("int_value", w0[26:15], int_value);
        chk("int_valid", w0[26:15] >= 12'h017, int_valid);
        chk("frac_value", {w0[14:3], a_flo}, frac_value);
        chk("ref_div_code", a_rdiv, ref_div_code);
        chk("ref_div_ratio", ratio(a_rdiv), ref_div_ratio);
        chk("doubler_halving", {a_dbl, w2[21]}, {ref_doubler, ref_halving_flag});
        chk("pump_current_code", a_cpi, pump_current_code);
        chk("word2", {w2[28], w2[22]}, {cycle_slip_reduction, prescaler_select});
        chk("word3", {w3[7:5], w3[3]}, {lock_detect_precision, pd_polarity, power_down, counter_reset});
        chk("power_down", {w3[5] | w3[4], w3[5] | w3[3], w3[5]}, {pump_tristate, counters_hold, lock_detect_clear});
        chk("word4", {w4[24:23], w4[20:7]}, {negative_bleed_control, clock_divider_mode, clock_divider_value});
        chk("monitor_en", w0[30:27] != 4'h0, monitor_output_en);
        if (w0[30:27] != 4'h0) chk("monitor", mon_exp(w0[30:27]), monitor_output);
    endtask : check_all

    task automatic put(input logic [31:0] w);
        int u;
        int m;
        @(posedge clock);
        u = n_upd;
        m = n_mrst;
        ref_div_point <= 1'($urandom());
        n_div_point <= 1'($urandom());
        lock_point <= 1'($urandom());
        host.write_word(w, 3 + int'($urandom_range(3)), 1'b1);
        repeat (8) @(posedge clock);
        #1;
        last_w = w;
        case (w[2:0])
            3'h0: begin
                u = u + 1;
                m = m + int'(!w3[14]);
                w0 = w;
                a_flo = w1[27:15];
                a_rdiv = w2[19:15];
                a_dbl = w2[20];
                a_cpi = w2[27:24];
            end
            3'h1: w1 = w;
            3'h2: w2 = w;
            3'h3: w3 = w;
            3'h4: w4 = w;
            default: ;
        endcase
        chk("freq_update", u, n_upd);
        chk("modulator_reset", m, n_mrst);
        check_all();
    endtask : put

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {clock, resetn, ref_div_point, n_div_point, lock_point} = '0;
        clock_en = 1'b1;
        {w0, w1, w2, w3, w4, a_flo, a_rdiv, a_dbl, a_cpi, last_w} = '0;
        {miscompares, n_checks, n_upd, n_mrst} = '0;
        void'($urandom(20));
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
        check_all();
        $display("test reset done");
        for (int s = 0; s < 2; s++) begin
            put((mk(3'h3) & ~32'h0000_4000) | (32'(s) << 14));
            put(mk(3'h2));
            put(mk(3'h1));
            put(mk(3'h0));
        end
        $display("test buffered done");
        foreach (ints[i]) put((mk(3'h0) & ~32'h07ff_8000) | (32'(ints[i]) << 15));
        $display("test divider limits done");
        foreach (mons[i]) put((mk(3'h0) & ~32'h7800_0000) | (32'(mons[i]) << 27));
        $display("test monitor done");
        @(posedge clock);
        host.write_word($urandom(), 3, 1'b0);
        put(mk(3'h4));
        $display("test extra bits done");
        for (int c = 5; c < 8; c++) put(($urandom() & ~32'h7) | 32'(c));
        $display("test unused codes done");
        @(posedge clock);
        clock_en <= 1'b0;
        upd0 = n_upd;
        host.write_word(mk(3'h0), 3, 1'b1);
        repeat (8) @(posedge clock);
        #1;
        chk("freq_update", upd0, n_upd);
        check_all();
        @(posedge clock);
        clock_en <= 1'b1;
        $display("test clock enable done");
        repeat (24) put(mk(3'($urandom_range(4))));
        $display("test random done");
        test_done();
    end
endmodule : synth_serial_config_bank_tb_top
`default_nettype wire
